/* File: inc/rx_gain_defs.svh */
// Constants for the receiver amplifier gain register bank
`ifndef RX_GAIN_DEFS_SVH
`define RX_GAIN_DEFS_SVH

`define RX_DATA_W 32
`define RX_STRB_W 4
`define RX_BYTE_W 8
`define RX_CODE_W 7
`define RX_ATTEN_W 10
`define RX_IDX_W 7
`define RX_ADDR_LSB 2
`define RX_ALIGN_OK 2'h0

`define RX_IDX_PAGE 7'h00
`define RX_IDX_LEFT_LINE 7'h24
`define RX_IDX_RIGHT_LINE 7'h25
`define RX_IDX_LEFT_INPUT 7'h26
`define RX_IDX_STATUS 7'h7E
`define RX_IDX_BOOK 7'h7F

`define RX_BOOK_RECEIVER 8'h00
`define RX_PAGE_RECEIVER 8'h01
`define RX_SEL_RESET 8'h00

`define RX_CODE_MUTE 7'h7F
`define RX_CODE_RSV_LO 7'h76
`define RX_CODE_RSV_HI 7'h7E
`define RX_LUT_DEPTH 118
`define RX_ATTEN_NONE 10'h000

`define RX_LINK_BIT 7
`define RX_LINK_RESET 1'b0
`define RX_GAIN_RESET 7'h7F

`define RX_ST_LEFT_LINE_ON 0
`define RX_ST_RIGHT_LINE_ON 1
`define RX_ST_LEFT_INPUT_ON 2
`define RX_ST_LINK 3
`define RX_ST_RSV_SEEN 4

`endif

/* File: inc/rx_gain_pkg.sv */
// Types and shared helpers for the receiver amplifier gain bank
`include "rx_gain_defs.svh"

package rx_gain_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    typedef struct packed {
        logic connected;
        logic reserved;
        logic [`RX_ATTEN_W-1:0] atten_tenth_db;
        logic [`RX_CODE_W-1:0] code;
    } path_ctrl_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [`RX_STRB_W-1:0] strb;
        logic [`RX_DATA_W-1:0] wdata;
    } apb_req_t;

    function automatic logic code_is_reserved(
        input logic [`RX_CODE_W-1:0] code
    );
        return (code >= `RX_CODE_RSV_LO) && (code <= `RX_CODE_RSV_HI);
    endfunction

endpackage

/* File: src/gain_lut.sv */
// Code to attenuation lookup for one receiver path
`timescale 1ns/1ps
`include "rx_gain_defs.svh"

module gain_lut (
    input wire logic [`RX_CODE_W-1:0] code,
    output rx_gain_pkg::path_ctrl_t path
);

    // Attenuation in tenths of a dB; the table is non-uniform up high
    localparam logic [`RX_ATTEN_W-1:0] LUT [0:`RX_LUT_DEPTH-1] = '{
        10'h000, 10'h005, 10'h00A, 10'h00F, 10'h014, 10'h019, 10'h01E,
        10'h023, 10'h028, 10'h02D, 10'h032, 10'h037, 10'h03C, 10'h041,
        10'h046, 10'h04B, 10'h050, 10'h055, 10'h05A, 10'h05F, 10'h064,
        10'h069, 10'h06E, 10'h073, 10'h078, 10'h07D, 10'h082, 10'h087,
        10'h08D, 10'h092, 10'h097, 10'h09C, 10'h0A0, 10'h0A5, 10'h0AB,
        10'h0AF, 10'h0B5, 10'h0BA, 10'h0BF, 10'h0C4, 10'h0C9, 10'h0CE,
        10'h0D3, 10'h0D8, 10'h0DD, 10'h0E2, 10'h0E7, 10'h0EC, 10'h0F1,
        10'h0F6, 10'h0FB, 10'h100, 10'h105, 10'h10A, 10'h10F, 10'h114,
        10'h119, 10'h11E, 10'h123, 10'h128, 10'h12D, 10'h132, 10'h137,
        10'h13C, 10'h141, 10'h147, 10'h14B, 10'h150, 10'h155, 10'h15A,
        10'h160, 10'h165, 10'h169, 10'h16F, 10'h173, 10'h179, 10'h17E,
        10'h183, 10'h188, 10'h18D, 10'h192, 10'h197, 10'h19C, 10'h1A2,
        10'h1A5, 10'h1AB, 10'h1B0, 10'h1B6, 10'h1BB, 10'h1C0, 10'h1C4,
        10'h1CA, 10'h1CE, 10'h1D3, 10'h1DA, 10'h1DF, 10'h1E2, 10'h1E7,
        10'h1ED, 10'h1F4, 10'h1F7, 10'h1FE, 10'h202, 10'h206, 10'h20B,
        10'h20F, 10'h219, 10'h21E, 10'h22A, 10'h237, 10'h247, 10'h25A,
        10'h273, 10'h283, 10'h296, 10'h2AF, 10'h2D3, 10'h30F
    };

    always_comb begin
        path.code = code;
        path.reserved = rx_gain_pkg::code_is_reserved(code); // RULE_03
        // Mute code and reserved codes both leave the path open
        path.connected = (code != `RX_CODE_MUTE) && !path.reserved; // RULE_02
        path.atten_tenth_db = `RX_ATTEN_NONE;
        if (path.connected) begin
            path.atten_tenth_db = LUT[code]; // RULE_10 RULE_11 RULE_12 RULE_14
        end
    end

endmodule // gain_lut

/* File: src/path_reg.sv */
// Output register stage for one receiver path control word
`timescale 1ns/1ps
`include "rx_gain_defs.svh"

module path_reg (
    input wire logic pclk,
    input wire logic presetn,
    input rx_gain_pkg::path_ctrl_t path_next,
    output rx_gain_pkg::path_ctrl_t path_q
);

    // Reset state is the disconnected path
    localparam rx_gain_pkg::path_ctrl_t PATH_RESET = '{
        connected: 1'b0,
        reserved: 1'b0,
        atten_tenth_db: `RX_ATTEN_NONE,
        code: `RX_GAIN_RESET
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            path_q <= PATH_RESET;
        end else begin
            path_q <= path_next;
        end
    end

endmodule // path_reg

/* File: src/receiver_amp_gain_regs.sv */
// APB register bank steering the receiver amplifier path gains
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "rx_gain_defs.svh"

// Contract
// RULE_01 - Left line to positive driver gain field
// RULE_02 - All ones disconnects left line path, reset
// RULE_03 - Host never writes reserved codes 76h-7Eh
// RULE_04 - Link bit makes left field drive both
// RULE_05 - Host sets link only for differential load
// RULE_06 - Right line gain field, bits 6:0, reset ones
// RULE_07 - All ones disconnects right line path
// RULE_08 - Third register bit 7 reads zero only
// RULE_09 - Left input gain field, bits 6:0, reset ones
// RULE_10 - Code zero 0 dB, half-dB low steps
// RULE_11 - Fixed non-uniform table for every code
// RULE_12 - Code 75h gives -78.3 dB maximum
// RULE_13 - Registers selected by book, page, index
// RULE_14 - Combinational lookup, reads return stored field
module receiver_amp_gain_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [`RX_DATA_W-1:0] pwdata,
    input wire logic [`RX_STRB_W-1:0] pstrb,
    output logic [`RX_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic link_shared,
    output rx_gain_pkg::path_ctrl_t left_line_path,
    output rx_gain_pkg::path_ctrl_t right_line_path,
    output rx_gain_pkg::path_ctrl_t left_input_path
);

    localparam int IDX_TOP = `RX_ADDR_LSB + `RX_IDX_W;

    rx_gain_pkg::apb_req_t req;
    rx_gain_pkg::bus_state_t bus_state_reg;
    rx_gain_pkg::bus_state_t bus_state_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [`RX_DATA_W-1:0] prdata_reg;
    logic [`RX_DATA_W-1:0] prdata_next;

    logic [`RX_BYTE_W-1:0] page_reg;
    logic [`RX_BYTE_W-1:0] page_next;
    logic [`RX_BYTE_W-1:0] book_reg;
    logic [`RX_BYTE_W-1:0] book_next;
    logic [`RX_CODE_W-1:0] left_line_reg;
    logic [`RX_CODE_W-1:0] left_line_next;
    logic [`RX_CODE_W-1:0] right_line_reg;
    logic [`RX_CODE_W-1:0] right_line_next;
    logic link_reg;
    logic link_next;
    logic [`RX_CODE_W-1:0] left_input_reg;
    logic [`RX_CODE_W-1:0] left_input_next;
    logic rsv_seen_reg;
    logic rsv_seen_next;

    logic [`RX_IDX_W-1:0] idx;
    logic aligned;
    logic in_range;
    logic in_rx_page;
    logic mapped;
    logic take;
    logic done;
    logic wr_en;
    logic [`RX_BYTE_W-1:0] wbyte;
    logic [`RX_DATA_W-1:0] rd_value;
    logic rsv_write;
    logic [`RX_CODE_W-1:0] right_eff;

    rx_gain_pkg::path_ctrl_t left_line_dec;
    rx_gain_pkg::path_ctrl_t right_line_dec;
    rx_gain_pkg::path_ctrl_t left_input_dec;

    function automatic logic [`RX_DATA_W-1:0] gain_word(
        input logic link,
        input logic [`RX_CODE_W-1:0] code
    );
        logic [`RX_DATA_W-1:0] w;
        w = '0;
        w[`RX_CODE_W-1:0] = code;
        w[`RX_LINK_BIT] = link;
        return w;
    endfunction

    always_comb begin
        req.sel = psel;
        req.enable = penable;
        req.write = pwrite;
        req.strb = pstrb;
        req.wdata = pwdata;
    end

    // Address decode; the book and page select the receiver bank
    always_comb begin
        idx = paddr[`RX_ADDR_LSB +: `RX_IDX_W];
        aligned = (paddr[`RX_ADDR_LSB-1:0] == `RX_ALIGN_OK);
        in_range = ((paddr >> IDX_TOP) == '0);
        in_rx_page = (book_reg == `RX_BOOK_RECEIVER) &&
                     (page_reg == `RX_PAGE_RECEIVER); // RULE_13
        case (idx)
            `RX_IDX_PAGE,
            `RX_IDX_BOOK,
            `RX_IDX_STATUS: begin
                mapped = aligned && in_range;
            end
            `RX_IDX_LEFT_LINE,
            `RX_IDX_RIGHT_LINE,
            `RX_IDX_LEFT_INPUT: begin
                mapped = aligned && in_range && in_rx_page; // RULE_13
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read data; gain fields come back exactly as stored
    always_comb begin
        rd_value = '0;
        case (idx)
            `RX_IDX_PAGE: begin
                rd_value[`RX_BYTE_W-1:0] = page_reg;
            end
            `RX_IDX_BOOK: begin
                rd_value[`RX_BYTE_W-1:0] = book_reg;
            end
            `RX_IDX_LEFT_LINE: begin
                rd_value = gain_word(1'b0, left_line_reg); // RULE_14
            end
            `RX_IDX_RIGHT_LINE: begin
                rd_value = gain_word(link_reg, right_line_reg); // RULE_14
            end
            `RX_IDX_LEFT_INPUT: begin
                rd_value = gain_word(1'b0, left_input_reg); // RULE_08
            end
            `RX_IDX_STATUS: begin
                rd_value[`RX_ST_LEFT_LINE_ON] = left_line_path.connected;
                rd_value[`RX_ST_RIGHT_LINE_ON] = right_line_path.connected;
                rd_value[`RX_ST_LEFT_INPUT_ON] = left_input_path.connected;
                rd_value[`RX_ST_LINK] = link_reg;
                rd_value[`RX_ST_RSV_SEEN] = rsv_seen_reg;
            end
            default: begin
                rd_value = '0;
            end
        endcase
        if (!mapped) begin
            rd_value = '0;
        end
    end

    // Bus handshake: one wait state, answer registered
    always_comb begin
        take = req.sel && req.enable && (bus_state_reg == rx_gain_pkg::BUS_IDLE);
        done = req.sel && req.enable && pready_reg;
        bus_state_next = bus_state_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = '0;
        case (bus_state_reg)
            rx_gain_pkg::BUS_IDLE: begin
                if (take) begin
                    bus_state_next = rx_gain_pkg::BUS_ANSWER;
                    pready_next = 1'b1;
                    pslverr_next = !mapped;
                    prdata_next = req.write ? '0 : rd_value;
                end
            end
            rx_gain_pkg::BUS_ANSWER: begin
                bus_state_next = rx_gain_pkg::BUS_IDLE;
            end
            default: begin
                bus_state_next = rx_gain_pkg::BUS_IDLE;
            end
        endcase
    end

    // Writes land only at the completing edge; lane 0 carries the byte
    always_comb begin
        wr_en = done && req.write && mapped && req.strb[0];
        wbyte = req.wdata[`RX_BYTE_W-1:0];
        page_next = page_reg;
        book_next = book_reg;
        left_line_next = left_line_reg;
        right_line_next = right_line_reg;
        link_next = link_reg;
        left_input_next = left_input_reg;
        rsv_write = 1'b0;
        if (wr_en) begin
            case (idx)
                `RX_IDX_PAGE: begin
                    page_next = wbyte; // RULE_13
                end
                `RX_IDX_BOOK: begin
                    book_next = wbyte; // RULE_13
                end
                `RX_IDX_LEFT_LINE: begin
                    left_line_next = wbyte[`RX_CODE_W-1:0]; // RULE_01
                end
                `RX_IDX_RIGHT_LINE: begin
                    right_line_next = wbyte[`RX_CODE_W-1:0]; // RULE_06
                    // No lock on the link bit; load type is up to software
                    link_next = wbyte[`RX_LINK_BIT]; // RULE_04 RULE_05
                end
                `RX_IDX_LEFT_INPUT: begin
                    // Bit 7 is not stored, so it always reads zero
                    left_input_next = wbyte[`RX_CODE_W-1:0]; // RULE_08 RULE_09
                end
                default: begin
                    page_next = page_reg;
                end
            endcase
            if (idx == `RX_IDX_LEFT_LINE || idx == `RX_IDX_RIGHT_LINE ||
                idx == `RX_IDX_LEFT_INPUT) begin
                // Stored as written; only flagged for software to see
                rsv_write = rx_gain_pkg::code_is_reserved(
                    wbyte[`RX_CODE_W-1:0]); // RULE_03
            end
        end
    end

    // Sticky flag: a new reserved write wins over a clear
    always_comb begin
        rsv_seen_next = rsv_seen_reg;
        if (wr_en && idx == `RX_IDX_STATUS && wbyte[`RX_ST_RSV_SEEN]) begin
            rsv_seen_next = 1'b0;
        end
        if (rsv_write) begin
            rsv_seen_next = 1'b1;
        end
    end

    // Effective codes feed the lookups
    always_comb begin
        right_eff = link_reg ? left_line_reg : right_line_reg; // RULE_04
    end

    gain_lut u_lut_left_line (
        .code(left_line_reg),
        .path(left_line_dec)
    );

    gain_lut u_lut_right_line (
        .code(right_eff),
        .path(right_line_dec)
    );

    gain_lut u_lut_left_input (
        .code(left_input_reg),
        .path(left_input_dec)
    );

    path_reg u_out_left_line (
        .pclk(pclk),
        .presetn(presetn),
        .path_next(left_line_dec),
        .path_q(left_line_path)
    );

    path_reg u_out_right_line (
        .pclk(pclk),
        .presetn(presetn),
        .path_next(right_line_dec),
        .path_q(right_line_path)
    );

    path_reg u_out_left_input (
        .pclk(pclk),
        .presetn(presetn),
        .path_next(left_input_dec),
        .path_q(left_input_path)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_reg <= rx_gain_pkg::BUS_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_reg <= `RX_SEL_RESET;
            book_reg <= `RX_SEL_RESET;
            left_line_reg <= `RX_GAIN_RESET; // RULE_02
            right_line_reg <= `RX_GAIN_RESET; // RULE_06 RULE_07
            link_reg <= `RX_LINK_RESET;
            left_input_reg <= `RX_GAIN_RESET; // RULE_09
            rsv_seen_reg <= 1'b0;
            link_shared <= `RX_LINK_RESET;
        end else begin
            page_reg <= page_next;
            book_reg <= book_next;
            left_line_reg <= left_line_next;
            right_line_reg <= right_line_next;
            link_reg <= link_next;
            left_input_reg <= left_input_next;
            rsv_seen_reg <= rsv_seen_next;
            link_shared <= link_next;
        end
    end

    always_comb begin
        prdata = prdata_reg;
        pready = pready_reg;
        pslverr = pslverr_reg;
    end

endmodule // receiver_amp_gain_regs

/* File: bench/rx_gain_checker.sv */
// Port assertions for the receiver gain bank
`timescale 1ns/1ps
`include "rx_gain_defs.svh"
module rx_gain_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [`RX_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_shared,
    input rx_gain_pkg::path_ctrl_t left_line_path,
    input rx_gain_pkg::path_ctrl_t right_line_path,
    input rx_gain_pkg::path_ctrl_t left_input_path
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    sequence taken;
        psel && penable && !pready;
    endsequence
    // Three steady cycles so the one-edge path lag has settled
    sequence linked_steady;
        (link_shared && $stable(left_line_path.code)) [*3];
    endsequence
    AST_ANSWER: assert property (taken |=> pready ##1 !pready)
        else $error("answer not one cycle after take");
    AST_ERR_ANSWER: assert property (pslverr |-> pready)
        else $error("error outside answer");
    AST_RD_IDLE: assert property (!rd_ok |-> prdata == '0)
        else $error("read data outside read answer");
    AST_LEFT_DISC: assert property (
        left_line_path.code == 7'h7F |-> !left_line_path.connected &&
        left_line_path.atten_tenth_db == 0)
        else $error("left line not disconnected");
    AST_RIGHT_DISC: assert property (
        right_line_path.code == 7'h7F |-> !right_line_path.connected)
        else $error("right line not disconnected");
    AST_INPUT_DISC: assert property (
        left_input_path.code == 7'h7F |-> !left_input_path.connected)
        else $error("left input not disconnected");
    AST_ZERO_DB: assert property (
        left_line_path.code == 7'h00 |-> left_line_path.connected &&
        left_line_path.atten_tenth_db == 0)
        else $error("code zero not 0 dB");
    AST_RSV_CODE: assert property (
        left_line_path.code inside {[7'h76:7'h7E]} |->
        left_line_path.reserved && !left_line_path.connected)
        else $error("reserved code connected");
    AST_MAX_ATTEN: assert property (
        left_line_path.code == 7'h75 |->
        left_line_path.atten_tenth_db == 10'h30F)
        else $error("largest attenuation wrong");
    AST_LINK: assert property (
        linked_steady |-> right_line_path.code == left_line_path.code)
        else $error("linked right path not following left");
    AST_RD_B7: assert property (
        rd_ok && paddr[8:2] inside {7'h24, 7'h26} |-> !prdata[7])
        else $error("bit 7 reads one");
    AST_RD_FIELD: assert property (
        rd_ok && paddr[8:2] == 7'h24 |-> prdata[6:0] == left_line_path.code)
        else $error("read differs from stored field");
endmodule // rx_gain_checker
bind receiver_amp_gain_regs rx_gain_checker #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_shared(link_shared),
    .left_line_path(left_line_path), .right_line_path(right_line_path),
    .left_input_path(left_input_path));

/* File: bench/apb_host.sv */
// Host model issuing APB transfers
`timescale 1ns/1ps
module apb_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= (a == 12'h098) ? (d & 32'hFFFFFF7F) : d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Request held until pready is seen high
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // apb_host

/* File: bench/testbench.sv */
// Self-checking bench for the receiver gain bank
`timescale 1ns/1ps
module testbench;
    localparam logic [6:0] TC [9] = '{7'h00, 7'h01, 7'h1C, 7'h3F, 7'h40,
        7'h41, 7'h60, 7'h74, 7'h75};
    localparam logic [9:0] TA [9] = '{10'h000, 10'h005, 10'h08D, 10'h13C,
        10'h141, 10'h147, 10'h1E2, 10'h2D3, 10'h30F};
    localparam logic [11:0] ADR [3] = '{12'h090, 12'h094, 12'h098};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, link_shared, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] d;
    rx_gain_pkg::path_ctrl_t left_line_path, right_line_path;
    rx_gain_pkg::path_ctrl_t left_input_path;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int g[3] = '{127, 127, 127};
    int lnk = 0;
    int rsv = 0;
    int i;
    integer seed;
    initial begin
        forever #4 pclk = ~pclk;
    end
    apb_host host (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    receiver_amp_gain_regs dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_shared(link_shared),
        .left_line_path(left_line_path), .right_line_path(right_line_path),
        .left_input_path(left_input_path));
    function automatic rx_gain_pkg::path_ctrl_t exp_path(logic [6:0] c);
        rx_gain_pkg::path_ctrl_t p;
        p = '0;
        p.code = c;
        p.reserved = (c >= 7'h76) && (c <= 7'h7E);
        foreach (TC[k]) if (TC[k] == c) begin
            p.connected = 1'b1;
            p.atten_tenth_db = TA[k];
        end
        return p;
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_p(rx_gain_pkg::path_ctrl_t got,
        rx_gain_pkg::path_ctrl_t exp);
        cmp(32'(got), 32'(exp));
    endtask
    task automatic put(int k, logic [7:0] v);
        host.xfer(1'b1, ADR[k], {24'h0, v}, 4'hF, rd, er);
        cmp(er, 0);
        g[k] = v[6:0];
        if (k == 1) lnk = v[7];
        if (v[6:0] >= 7'h76 && v[6:0] <= 7'h7E) rsv = 1;
    endtask
    task automatic check_all;
        rx_gain_pkg::path_ctrl_t e0, e1, e2;
        logic [4:0] st;
        e0 = exp_path(g[0]);
        e1 = exp_path(lnk ? g[0] : g[1]);
        e2 = exp_path(g[2]);
        st = {rsv[0], lnk[0], e2.connected, e1.connected, e0.connected};
        for (int k = 0; k < 3; k++) begin
            host.xfer(1'b0, ADR[k], 32'h0, 4'hF, rd, er);
            cmp(rd, (k == 1) ? ((lnk << 7) | g[1]) : g[k]);
        end
        // Status shows effective path state and the sticky flag
        host.xfer(1'b0, 12'h1F8, 32'h0, 4'hF, rd, er);
        cmp(rd, st);
        cmp_p(left_line_path, e0);
        cmp_p(right_line_path, e1);
        cmp_p(left_input_path, e2);
        cmp(link_shared, lnk);
    endtask
    task automatic close_out;
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the fewer than a thousand cycles needed
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out;
        end
    end
    initial begin
        seed = 32'h78030E9D;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        host.xfer(1'b0, 12'h090, 32'h0, 4'hF, rd, er);
        cmp(er, 1);
        host.xfer(1'b0, 12'h000, 32'h0, 4'hF, rd, er);
        cmp(rd, 0);
        host.xfer(1'b1, 12'h000, 32'h01, 4'hF, rd, er);
        check_all;
        foreach (TC[k]) begin
            put(0, {1'b0, TC[k]});
            put(1, {1'b0, TC[(k + 3) % 9]});
            put(2, {1'b0, TC[(k + 5) % 9]});
            check_all;
        end
        repeat (16) begin
            i = $unsigned($random(seed)) % 3;
            d = {1'b0, TC[$unsigned($random(seed)) % 9]};
            if (i == 1) d[7] = $random(seed);
            put(i, d);
            check_all;
        end
        // Misbehaving host: reserved codes must only raise the flag
        put(0, 8'h76);
        put(2, 8'h7E);
        check_all;
        host.xfer(1'b1, 12'h1F8, 32'h10, 4'hF, rd, er);
        cmp(er, 0);
        rsv = 0;
        put(0, 8'h3F);
        put(1, 8'h81);
        check_all;
        put(0, 8'h7F);
        put(1, 8'h7F);
        check_all;
        host.xfer(1'b1, 12'h098, 32'h0, 4'h0, rd, er);
        cmp(er, 0);
        check_all;
        host.xfer(1'b0, 12'h091, 32'h0, 4'hF, rd, er);
        cmp(er, 1);
        host.xfer(1'b0, 12'h010, 32'h0, 4'hF, rd, er);
        cmp(er, 1);
        host.xfer(1'b1, 12'h1FC, 32'h01, 4'hF, rd, er);
        host.xfer(1'b1, 12'h094, 32'h05, 4'hF, rd, er);
        cmp(er, 1);
        host.xfer(1'b1, 12'h1FC, 32'h00, 4'hF, rd, er);
        check_all;
        close_out;
    end
endmodule // testbench
